/* File: bench/mcs_regs_checker.sv */
/*
   Port-level assertions for the configuration and first status registers.
   Assumes one device clock and a synchronous active-high reset; bound below.
*/
module mcs_regs_checker (
   input wire logic                             CLOCK,
   input wire logic                             RESET,
   input wire mcs_pkg::mcs_reg_req_type         REG_REQ,
   input wire logic [7:0]                       REG_RDATA,
   input wire logic                             REG_RVALID,
   input wire logic                             LOCAL_TEMP_COND,
   input wire logic [7:0]                       STATUS_TWO_FLAGS,
   input wire logic [mcs_pkg::MCS_PWM_CHANNELS-1:0]
                    [mcs_pkg::MCS_DUTY_WIDTH-1:0] FAN_LOOP_DUTY,
   input wire logic [mcs_pkg::MCS_PWM_CHANNELS-1:0]
                    [mcs_pkg::MCS_DUTY_WIDTH-1:0] PWM_DUTY,
   input wire logic                             MONITOR_ENABLE,
   input wire logic                             USE_PROGRAMMED_LIMITS,
   input wire logic                             CPU_THERMAL_BUS_ENABLE,
   input wire logic                             LIMITS_LOCKED,
   input wire logic                             FAN_FORCED_FULL
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////
   // one domain, so clock and reset are given once
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RESET);

   ////////////////////////////////////////////////////////////////////////
   // fan override; run bit compared over two cycles since force lags cfg
   property p_run_off; !$past(MONITOR_ENABLE) && !MONITOR_ENABLE |-> FAN_FORCED_FULL; endproperty
   a_run_off: assert property (p_run_off) else $error("fans not forced with run off");
   property p_forced_duty; FAN_FORCED_FULL |-> PWM_DUTY == 24'hFF_FFFF; endproperty
   a_forced_duty: assert property (p_forced_duty) else $error("forced duty not full");
   property p_loop_duty; !FAN_FORCED_FULL |-> PWM_DUTY == $past(FAN_LOOP_DUTY); endproperty
   a_loop_duty: assert property (p_loop_duty) else $error("duty not from fan loop");
   property p_limits; MONITOR_ENABLE == USE_PROGRAMMED_LIMITS; endproperty
   a_limits: assert property (p_limits) else $error("limit select disagrees with run");
   // lock and what it freezes
   property p_lock_sticky; LIMITS_LOCKED |=> LIMITS_LOCKED; endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");
   property p_bus_frozen; LIMITS_LOCKED |=> $stable(CPU_THERMAL_BUS_ENABLE); endproperty
   a_bus_frozen: assert property (p_bus_frozen) else $error("bus enable moved");
   property p_run_write;
      REG_REQ.write && REG_REQ.addr == mcs_pkg::MCS_CFG_ADDR
         |=> MONITOR_ENABLE == $past(REG_REQ.wdata[0]);
   endproperty
   a_run_write: assert property (p_run_write) else $error("run bit not written");
   // register reads
   property p_cfg_read;
      REG_REQ.read && REG_REQ.addr == mcs_pkg::MCS_CFG_ADDR
         |=> REG_RVALID && REG_RDATA[7:6] == 2'h0 && REG_RDATA[2];
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config fixed bits wrong");
   property p_flag_seen;
      LOCAL_TEMP_COND ##1 (REG_REQ.read && REG_REQ.addr == mcs_pkg::MCS_STAT1_ADDR)
         |=> REG_RDATA[5];
   endproperty
   a_flag_seen: assert property (p_flag_seen) else $error("local temp flag missing");
   // summary is registered once, then read out one edge later
   property p_summary;
      REG_REQ.read && REG_REQ.addr == mcs_pkg::MCS_STAT1_ADDR && !$past(RESET)
         |=> REG_RDATA[7] == |$past(STATUS_TWO_FLAGS, 2);
   endproperty
   a_summary: assert property (p_summary) else $error("summary bit wrong");
endmodule : mcs_regs_checker

bind mcs_regs mcs_regs_checker u_chk (.CLOCK, .RESET, .REG_REQ, .REG_RDATA, .REG_RVALID,
   .LOCAL_TEMP_COND, .STATUS_TWO_FLAGS, .FAN_LOOP_DUTY, .PWM_DUTY, .MONITOR_ENABLE,
   .USE_PROGRAMMED_LIMITS, .CPU_THERMAL_BUS_ENABLE, .LIMITS_LOCKED, .FAN_FORCED_FULL);

/* File: bench/mcs_regs_tb_top.sv */
/*
   Self-checking bench for the configuration and first status registers.
   Assumes the checker is bound to the design; inputs move 1 ns after edges.
*/
module mcs_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     clock, reset, rvalid, tmr_sel, tlim, pin, ctl;
   logic                     mon_en, use_prog, bus_en, locked, forced;
   mcs_pkg::mcs_reg_req_type req;
   logic [7:0]               rdata, st2;
   logic [6:0]               cnd;
   logic [23:0]              loop, pwm;
   int                       err_total, n_checks;

   mcs_regs dut (.CLOCK(clock), .RESET(reset), .REG_REQ(req), .REG_RDATA(rdata),
      .REG_RVALID(rvalid), .TWO_HALF_VOLT_COND(cnd[0]), .CORE_VOLT_COND(cnd[1]),
      .SUPPLY_VOLT_COND(cnd[2]), .FIVE_VOLT_COND(cnd[3]), .REMOTE_ONE_TEMP_COND(cnd[4]),
      .LOCAL_TEMP_COND(cnd[5]), .REMOTE_TWO_TEMP_COND(cnd[6]), .PIN_IS_TIMER_INPUT(tmr_sel),
      .TIMER_LIMIT_COND(tlim), .STATUS_TWO_FLAGS(st2), .OVERTEMP_PIN(pin),
      .CONTROL_TEMP_LIMIT(ctl), .FAN_LOOP_DUTY(loop), .PWM_DUTY(pwm),
      .MONITOR_ENABLE(mon_en), .USE_PROGRAMMED_LIMITS(use_prog),
      .CPU_THERMAL_BUS_ENABLE(bus_en), .LIMITS_LOCKED(locked), .FAN_FORCED_FULL(forced));

   ////////////////////////////////////////////////////////////////////////
   // 25 mhz clock
   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers; every drive lands 1 ns after the edge to avoid races
   task automatic step; @(posedge clock); #1; endtask : step
   // wide enough for duty plus the flag bits packed in front of it
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req = '{a, d, 1'h1, 1'h0};
      step;
      // idle edge after each access so a strobe never moves twice at once
      req.write = 1'h0;
      step;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      req = '{a, 8'h00, 1'h0, 1'h1};
      step;
      req.read = 1'h0;
      cmp(rvalid, 1'h1);
      cmp(rdata, e);
      step;
   endtask : rd
   // bounded wait; the synchroniser delay is not fixed exactly
   task automatic wait_forced(input logic v);
      for (int i = 0; i < 8 && forced !== v; i++) step;
      cmp(forced, v);
      if (forced !== v) print_verdict;
   endtask : wait_forced
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      rd(8'h40, 8'h04);
      rd(8'h41, 8'h00);
      rd(8'h7E, 8'h00);
      cmp(pwm, 24'hFF_FFFF);
      cmp(mon_en, 1'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_fan;
      wr(8'h40, 8'hF1);
      rd(8'h40, 8'h35);
      cmp({mon_en, use_prog, bus_en}, 3'h7);
      cmp(pwm, loop);
      ctl = 1'h1;
      step;
      cmp(forced, 1'h1);
      ctl = 1'h0;
      wait_forced(1'h0);
      pin = 1'h1;
      wait_forced(1'h1);
      pin = 1'h0;
      wait_forced(1'h0);
      wr(8'h40, 8'h11);
      ctl = 1'h1;
      repeat (2) step;
      cmp(forced, 1'h0);
      ctl = 1'h0;
      wr(8'h40, 8'h19);
      step;
      cmp(pwm, 24'hFF_FFFF);
      wr(8'h40, 8'h11);
      step;
      cmp(pwm, loop);
      wr(8'h40, 8'h10);
      step;
      cmp({use_prog, forced, pwm}, 26'h1FF_FFFF);
      $display("test fan override done");
   endtask : t_fan
   task automatic t_lock;
      wr(8'h40, 8'h03);
      rd(8'h40, 8'h07);
      wr(8'h40, 8'hF8);
      rd(8'h40, 8'h0E);
      wr(8'h40, 8'h01);
      rd(8'h40, 8'h07);
      cmp({locked, bus_en}, 2'h2);
      $display("test lock done");
   endtask : t_lock
   task automatic t_status;
      cnd = 7'h7F;
      step;
      cnd = 7'h00;
      rd(8'h41, 8'h7F);
      rd(8'h41, 8'h00);
      cnd = 7'h20;
      step;
      rd(8'h41, 8'h20);
      cnd = 7'h00;
      rd(8'h41, 8'h20);
      rd(8'h41, 8'h00);
      tmr_sel = 1'h1;
      cnd = 7'h01;
      step;
      cnd = 7'h00;
      rd(8'h41, 8'h00);
      tlim = 1'h1;
      step;
      tlim = 1'h0;
      rd(8'h41, 8'h01);
      st2 = 8'h10;
      repeat (2) step;
      rd(8'h41, 8'h80);
      $display("test status done");
   endtask : t_status

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {reset, tmr_sel, tlim, pin, ctl} = 5'h10;
      {req, cnd, st2, err_total, n_checks} = '0;
      loop = 24'h12_3456;
      repeat (20) @(posedge clock);
      #1 reset = 1'h0;
      t_reset;
      t_fan;
      t_lock;
      t_status;
      print_verdict;
   end
endmodule : mcs_regs_tb_top

/* File: inc/mcs_pkg.sv */
/*
   Shared constants and carrier types for the monitor configuration and
   first limit-status register logic.
   Assumes one device clock and a synchronous power-on reset.
*/
package mcs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register offsets on the management port
   localparam logic [7:0] MCS_CFG_ADDR   = 8'h40;
   localparam logic [7:0] MCS_STAT1_ADDR = 8'h41;

   ////////////////////////////////////////////////////////////////////////
   // reset values and write masks
   localparam logic [7:0] MCS_CFG_RESET     = 8'h04;
   localparam logic [7:0] MCS_STAT1_RESET   = 8'h00;
   localparam logic [7:0] MCS_UNMAPPED_DATA = 8'h00;
   // run, lock, full speed, bus enable, manual override
   localparam logic [7:0] MCS_WMASK_OPEN    = 8'h3B;
   // only run and full speed once the limits are locked
   localparam logic [7:0] MCS_WMASK_LOCKED  = 8'h09;

   ////////////////////////////////////////////////////////////////////////
   // duty and widths
   localparam int unsigned MCS_PWM_CHANNELS = 3;
   localparam int unsigned MCS_DUTY_WIDTH   = 8;
   localparam int unsigned MCS_COND_COUNT   = 7;
   localparam logic [7:0]  MCS_FULL_DUTY    = 8'hFF;
   localparam logic [2:0]  MCS_SYNC_RESET   = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // configuration register layout, bit 7 first
   typedef struct packed {
      logic [1:0] reserved_field;
      logic       overtemp_override_in_manual;
      logic       cpu_thermal_bus_enable;
      logic       full_speed_override;
      logic       power_up_done;
      logic       limit_lock;
      logic       monitor_run;
   } mcs_config_type;

   // live out-of-limit conditions, bit 6 first
   typedef struct packed {
      logic remote_two_temp;
      logic local_temp;
      logic remote_one_temp;
      logic five_volt;
      logic supply_volt;
      logic core_volt;
      logic two_half_volt;
   } mcs_cond_type;

   // one register access from the serial port engine
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       write;
      logic       read;
   } mcs_reg_req_type;

endpackage : mcs_pkg

/* File: rtl/mcs_regs.sv */
/*
   Configuration register and first limit-status register of the thermal
   monitor and fan controller, with the fan duty override that they steer.
   Assumes the serial management engine delivers one decoded register
   access per cycle on the device clock, and that the measurement engines,
   fan loop and second status register live outside on the same clock.
   The overtemperature pin is asynchronous and is synchronised here.
*/
// Contract
// - run bit set: monitor and drive fans from programmed limits.
// - run bit clear: stop monitoring, use default limits, keep programmed ones.
// - run bit clear: every fan output goes to full duty.
// - lock bit is write-once; lockable registers stay read-only until power cycle.
// - once locked, config writes ignored except the run and full-speed bits.
// - read-only ready bit shows the device is powered and ready.
// - full-speed bit forces all fans full; clearing restores computed duty.
// - full-speed bit stays writable after lock.
// - bus thermal monitoring enable bit; read-only after lock.
// - manual override bit: overtemp pin or control limit forces fans full.
// - config register leaves reset holding 0x04, only ready bit set.
// - status bit 0: 2.5 V limit, or timer limit when pin is timer input.
// - status bits 4..6: remote one, local, remote two temperature limits.
// - status bit 7 is the OR of the second status register.
module mcs_regs (
   input  wire logic                                   CLOCK,
   input  wire logic                                   RESET,
   input  wire mcs_pkg::mcs_reg_req_type               REG_REQ,
   output logic [7:0]                                  REG_RDATA,
   output logic                                        REG_RVALID,
   input  wire logic                                   TWO_HALF_VOLT_COND,
   input  wire logic                                   CORE_VOLT_COND,
   input  wire logic                                   SUPPLY_VOLT_COND,
   input  wire logic                                   FIVE_VOLT_COND,
   input  wire logic                                   REMOTE_ONE_TEMP_COND,
   input  wire logic                                   LOCAL_TEMP_COND,
   input  wire logic                                   REMOTE_TWO_TEMP_COND,
   input  wire logic                                   PIN_IS_TIMER_INPUT,
   input  wire logic                                   TIMER_LIMIT_COND,
   input  wire logic [7:0]                             STATUS_TWO_FLAGS,
   input  wire logic                                   OVERTEMP_PIN,
   input  wire logic                                   CONTROL_TEMP_LIMIT,
   input  wire logic [mcs_pkg::MCS_PWM_CHANNELS-1:0]
                     [mcs_pkg::MCS_DUTY_WIDTH-1:0]     FAN_LOOP_DUTY,
   output logic [mcs_pkg::MCS_PWM_CHANNELS-1:0]
                [mcs_pkg::MCS_DUTY_WIDTH-1:0]          PWM_DUTY,
   output logic                                        MONITOR_ENABLE,
   output logic                                        USE_PROGRAMMED_LIMITS,
   output logic                                        CPU_THERMAL_BUS_ENABLE,
   output logic                                        LIMITS_LOCKED,
   output logic                                        FAN_FORCED_FULL
);

   ////////////////////////////////////////////////////////////////////////
   // state of this module, one struct
   typedef struct packed {
      mcs_pkg::mcs_config_type                 cfg;
      logic [2:0]                              ovt_sync;
      logic                                    ovt_level;
      logic [7:0]                              rdata;
      logic                                    rvalid;
      logic [mcs_pkg::MCS_PWM_CHANNELS-1:0]
            [mcs_pkg::MCS_DUTY_WIDTH-1:0]      duty;
      logic                                    forced;
   } mcs_regs_state_type;

   mcs_regs_state_type    state_q;
   mcs_regs_state_type    state_d;

   mcs_pkg::mcs_cond_type cond;
   logic [7:0]            status_flags;
   logic                  cfg_write;
   logic                  cfg_read;
   logic                  stat_read;
   logic [7:0]            cfg_bits;
   logic [7:0]            write_mask;
   logic [7:0]            cfg_merged;
   mcs_pkg::mcs_config_type cfg_next;
   logic                  overtemp_event;
   logic                  force_full;

   ////////////////////////////////////////////////////////////////////////
   // access decode; writes to other offsets are ignored, reads there still answer with MCS_UNMAPPED_DATA
   assign cfg_write = REG_REQ.write && (REG_REQ.addr == mcs_pkg::MCS_CFG_ADDR);
   assign cfg_read  = REG_REQ.read  && (REG_REQ.addr == mcs_pkg::MCS_CFG_ADDR);
   assign stat_read = REG_REQ.read  && (REG_REQ.addr == mcs_pkg::MCS_STAT1_ADDR);

   ////////////////////////////////////////////////////////////////////////
   // status bit sources
   always_comb begin
      // shared pin: timer limit replaces the 2.5 V flag
      cond.two_half_volt   = PIN_IS_TIMER_INPUT ? TIMER_LIMIT_COND
                                                : TWO_HALF_VOLT_COND;
      cond.core_volt       = CORE_VOLT_COND;
      cond.supply_volt     = SUPPLY_VOLT_COND;
      cond.five_volt       = FIVE_VOLT_COND;
      cond.remote_one_temp = REMOTE_ONE_TEMP_COND;
      cond.local_temp      = LOCAL_TEMP_COND;
      cond.remote_two_temp = REMOTE_TWO_TEMP_COND;
   end

   ////////////////////////////////////////////////////////////////////////
   // latched flags live in their own module; read strobe clears them
   mcs_status_one u_status_one (
      .clk        (CLOCK),
      .rst        (RESET),
      .cond       (cond),
      .status_two (STATUS_TWO_FLAGS),
      .read_clear (stat_read),
      .flags      (status_flags)
   );

   ////////////////////////////////////////////////////////////////////////
   // configuration write merge
   always_comb begin
      cfg_bits = state_q.cfg;
      // locked: only run and full speed may still change
      write_mask = state_q.cfg.limit_lock ? mcs_pkg::MCS_WMASK_LOCKED
                                          : mcs_pkg::MCS_WMASK_OPEN;
      cfg_merged = (cfg_bits & ~write_mask) | (REG_REQ.wdata & write_mask);
      cfg_next   = cfg_merged;
      // lock can only go up; a zero write never releases it
      cfg_next.limit_lock     = state_q.cfg.limit_lock
                              | cfg_merged[1];
      cfg_next.power_up_done  = 1'h1;
      cfg_next.reserved_field = 2'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // overtemperature pin: three stages, accept a change when the last two agree
   assign overtemp_event = state_q.ovt_level | CONTROL_TEMP_LIMIT;

   ////////////////////////////////////////////////////////////////////////
   // fan override decision; any single cause is enough
   always_comb begin
      force_full = 1'h0;
      if (!state_q.cfg.monitor_run) begin
         force_full = 1'h1;
      end
      if (state_q.cfg.full_speed_override) begin
         force_full = 1'h1;
      end
      // manual or disabled channels are overridden too
      if (state_q.cfg.overtemp_override_in_manual && overtemp_event) begin
         force_full = 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_d = state_q;

      // config register update; run and full speed survive the lock
      if (cfg_write) begin
         state_d.cfg = cfg_next;
      end

      // synchroniser; stage 0 feeds only stage 1
      state_d.ovt_sync = {state_q.ovt_sync[1:0], OVERTEMP_PIN};
      if (state_q.ovt_sync[1] == state_q.ovt_sync[2]) begin
         state_d.ovt_level = state_q.ovt_sync[2];
      end

      // read data: status is sampled before its clear takes effect
      state_d.rvalid = REG_REQ.read;
      if (cfg_read) begin
         state_d.rdata = state_q.cfg;
      end else if (stat_read) begin
         state_d.rdata = status_flags;
      end else if (REG_REQ.read) begin
         state_d.rdata = mcs_pkg::MCS_UNMAPPED_DATA;
      end

      // per-channel duty; forced outputs ignore the fan loop entirely
      state_d.forced = force_full;
      for (int ch = 0; ch < int'(mcs_pkg::MCS_PWM_CHANNELS); ch++) begin
         if (force_full) begin
            state_d.duty[ch] = mcs_pkg::MCS_FULL_DUTY;
         end else begin
            state_d.duty[ch] = FAN_LOOP_DUTY[ch];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; lock only falls with the power-on reset
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state_q.cfg       <= mcs_pkg::MCS_CFG_RESET;
         state_q.ovt_sync  <= mcs_pkg::MCS_SYNC_RESET;
         state_q.ovt_level <= 1'h0;
         state_q.rdata     <= mcs_pkg::MCS_UNMAPPED_DATA;
         state_q.rvalid    <= 1'h0;
         // fans start at full duty since run is clear out of reset
         state_q.duty      <= {mcs_pkg::MCS_PWM_CHANNELS{mcs_pkg::MCS_FULL_DUTY}};
         state_q.forced    <= 1'h1;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all from flops
   assign REG_RDATA  = state_q.rdata;
   assign REG_RVALID = state_q.rvalid;
   assign PWM_DUTY   = state_q.duty;

   // measurement engines stop while run is clear
   assign MONITOR_ENABLE         = state_q.cfg.monitor_run;
   // limit registers keep their contents; only their use is switched
   assign USE_PROGRAMMED_LIMITS  = state_q.cfg.monitor_run;
   assign CPU_THERMAL_BUS_ENABLE = state_q.cfg.cpu_thermal_bus_enable;
   // other lockable registers refuse writes while this is high
   assign LIMITS_LOCKED          = state_q.cfg.limit_lock;
   assign FAN_FORCED_FULL        = state_q.forced;

endmodule : mcs_regs

/* File: rtl/mcs_status_one.sv */
/*
   First limit-status register: latched out-of-limit flags that clear on
   read once their cause has gone, plus a summary of the second register.
   Assumes conditions and clear strobe come from logic on the same clock.
*/
module mcs_status_one (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire mcs_pkg::mcs_cond_type cond,
   input  wire logic [7:0]           status_two,
   input  wire logic                 read_clear,
   output logic [7:0]                flags
);

   typedef struct packed {
      logic [7:0] flags;
   } mcs_stat_state_type;

   mcs_stat_state_type state_q;
   mcs_stat_state_type state_d;
   logic [6:0]         cond_bits;

   assign cond_bits = cond;

   ////////////////////////////////////////////////////////////////////////
   // per-flag latch: a live condition always wins over the read clear
   always_comb begin
      state_d = state_q;
      for (int i = 0; i < int'(mcs_pkg::MCS_COND_COUNT); i++) begin
         state_d.flags[i] = cond_bits[i]
                          | (state_q.flags[i] & ~read_clear);
      end
      // summary is live, never latched here
      state_d.flags[7] = |status_two;
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q.flags <= mcs_pkg::MCS_STAT1_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign flags = state_q.flags;

endmodule : mcs_status_one
